//--- stepper_scale_consts.svh
// Register offsets, field positions, reset values and scaling constants
`ifndef STEPPER_SCALE_CONSTS_SVH
`define STEPPER_SCALE_CONSTS_SVH
`define CURRENT_SCALE_ADDR 7'h08
`define COIL_ZERO_ADDR 7'h09
`define HOLD_AMP_MSB 15
`define HOLD_AMP_LSB 12
`define RUN_AMP_MSB 4
`define RUN_AMP_LSB 1
`define COIL_CODE_MSB 10
`define COIL_CODE_LSB 1
`define AMP_RESET 4'h0
`define COIL_CODE_RESET 10'h000
`define PTR_ZERO_DEG 2'h0
`define PHASE_ZERO 7'h00
`define PHASE_QUARTER 7'h10
`define PHASE_HALF 7'h20
`define PHASE_THREE_QUARTER 7'h30
`define ADC_FULL_MV 16'h36B0
`define SUPPLY_FULL_MV 16'h6D60
`endif

//--- stepper_scale_pkg.sv
// Types shared by the current scale and coil voltage logic
package stepper_scale_pkg;
   typedef struct packed {
      logic wrStrobe;
      logic rdStrobe;
      logic [6:0] addr;
      logic [15:0] wrData;
   } reg_req_t;
   typedef struct packed {
      logic rdValid;
      logic [15:0] rdData;
      logic known;
   } reg_rsp_t;
   typedef struct packed {
      logic sampleValid;
      logic [6:0] phase;
      logic [11:0] adcCode;
   } coil_sample_t;
   typedef enum logic [1:0] {
      CAP_IDLE = 2'b00,
      CAP_SCALE = 2'b01
   } cap_state_t;
endpackage

//--- coil_voltage_scaler.sv
// Maps a captured ADC code onto the 10-bit supply-range coil voltage code
`timescale 1ns/1ns
`include "stepper_scale_consts.svh"
module coil_voltage_scaler (
   input wire logic [11:0] adcCode,
   output logic [9:0] coilCode
);
   logic [27:0] scaled;
   always_comb begin
      // ADC full scale is half the supply range; 28 V maps to code 1023
      scaled = 28'(adcCode) * 28'(`ADC_FULL_MV);
      scaled = scaled / 28'(`SUPPLY_FULL_MV);
      coilCode = scaled[11:2] | {10{|scaled[27:12]}};
   end
endmodule

//--- stepper_scale_regs.sv
// Current scale and zero-degree coil voltage registers of the stepper driver
`timescale 1ns/1ns
`include "stepper_scale_consts.svh"
module stepper_scale_regs (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire stepper_scale_pkg::reg_req_t regReq,
   output stepper_scale_pkg::reg_rsp_t regRsp,
   input wire logic holdMode,
   input wire stepper_scale_pkg::coil_sample_t coilSample,
   output logic [3:0] fullScaleSel,
   output logic [1:0] latestCapturePointer
);
   import stepper_scale_pkg::*;

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      logic [3:0] holdAmplitude;
      logic [3:0] runAmplitude;
      logic [9:0] coilVoltageCode;
      logic [1:0] pointer;
      cap_state_t capState;
      logic [11:0] pendingAdc;
      logic [3:0] fullScaleSel;
      reg_rsp_t rsp;
   } state_t;

   state_t cur;
   state_t next_cur;
   logic [9:0] scaledCode;

   // ----------------------------------------
   // Reset state
   // ----------------------------------------
   localparam state_t RESET_STATE = '{
      holdAmplitude: `AMP_RESET,
      runAmplitude: `AMP_RESET,
      coilVoltageCode: `COIL_CODE_RESET,
      pointer: `PTR_ZERO_DEG,
      capState: CAP_IDLE,
      pendingAdc: 12'h000,
      fullScaleSel: `AMP_RESET,
      rsp: '0
   };

   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   function automatic logic is_scale_addr(input logic [6:0] a);
      return a == `CURRENT_SCALE_ADDR;
   endfunction

   function automatic logic is_coil_zero_addr(input logic [6:0] a);
      return a == `COIL_ZERO_ADDR;
   endfunction

   function automatic logic is_mapped_addr(input logic [6:0] a);
      return is_scale_addr(a) || is_coil_zero_addr(a);
   endfunction

   function automatic logic write_hits_scale(input reg_req_t r);
      return r.wrStrobe && is_scale_addr(r.addr);
   endfunction

   // ----------------------------------------
   // Field extraction
   // ----------------------------------------
   function automatic logic [3:0] hold_field(input logic [15:0] w);
      return w[`HOLD_AMP_MSB:`HOLD_AMP_LSB];
   endfunction

   function automatic logic [3:0] run_field(input logic [15:0] w);
      return w[`RUN_AMP_MSB:`RUN_AMP_LSB];
   endfunction

   function automatic logic [3:0] amplitude_in_use(input logic hold,
      input logic [3:0] holdAmp, input logic [3:0] runAmp);
      return hold ? holdAmp : runAmp;
   endfunction

   // ----------------------------------------
   // Read words
   // ----------------------------------------
   function automatic logic [15:0] scale_word(input state_t s);
      logic [15:0] w;
      w = 16'h0000;
      w[`HOLD_AMP_MSB:`HOLD_AMP_LSB] = s.holdAmplitude;
      w[`RUN_AMP_MSB:`RUN_AMP_LSB] = s.runAmplitude;
      return w;
   endfunction

   function automatic logic [15:0] coil_zero_word(input state_t s);
      logic [15:0] w;
      w = 16'h0000;
      w[`COIL_CODE_MSB:`COIL_CODE_LSB] = s.coilVoltageCode;
      return w;
   endfunction

   function automatic logic [15:0] read_word(input logic [6:0] a, input state_t s);
      logic [15:0] w;
      w = 16'h0000;
      if (is_scale_addr(a)) begin
         w = scale_word(s);
      end else if (is_coil_zero_addr(a)) begin
         w = coil_zero_word(s);
      end
      return w;
   endfunction

   // ----------------------------------------
   // Phase decode
   // ----------------------------------------
   function automatic logic is_zero_phase(input coil_sample_t c);
      return c.sampleValid && (c.phase == `PHASE_ZERO);
   endfunction

   function automatic logic moves_pointer(input coil_sample_t c);
      logic hit;
      hit = 1'b0;
      if (c.sampleValid) begin
         hit = (c.phase == `PHASE_QUARTER) || (c.phase == `PHASE_HALF) ||
            (c.phase == `PHASE_THREE_QUARTER);
      end
      return hit;
   endfunction

   function automatic logic [1:0] pointer_for_phase(input logic [6:0] p);
      logic [1:0] ptr;
      ptr = `PTR_ZERO_DEG;
      unique case (p)
         `PHASE_QUARTER: ptr = 2'h1;
         `PHASE_HALF: ptr = 2'h2;
         `PHASE_THREE_QUARTER: ptr = 2'h3;
         default: ptr = `PTR_ZERO_DEG;
      endcase
      return ptr;
   endfunction

   // ----------------------------------------
   // Coil voltage scaling
   // ----------------------------------------
   coil_voltage_scaler coil_voltage_scaler_i (
      .adcCode(cur.pendingAdc),
      .coilCode(scaledCode)
   );

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      next_cur = cur;

      // ----------------------------------------
      // Register writes
      // ----------------------------------------
      if (write_hits_scale(regReq)) begin
         next_cur.holdAmplitude = hold_field(regReq.wrData);
         next_cur.runAmplitude = run_field(regReq.wrData);
      end

      // ----------------------------------------
      // Read answer
      // ----------------------------------------
      next_cur.rsp.rdValid = 1'b0;
      if (regReq.rdStrobe) begin
         next_cur.rsp.rdValid = 1'b1;
         next_cur.rsp.rdData = read_word(regReq.addr, cur);
         next_cur.rsp.known = is_mapped_addr(regReq.addr);
      end

      // ----------------------------------------
      // Latest capture pointer
      // ----------------------------------------
      if (moves_pointer(coilSample)) begin
         next_cur.pointer = pointer_for_phase(coilSample.phase);
      end

      // ----------------------------------------
      // Zero-degree capture
      // ----------------------------------------
      unique case (cur.capState)
         CAP_IDLE: begin
            if (is_zero_phase(coilSample)) begin
               next_cur.pendingAdc = coilSample.adcCode;
               next_cur.capState = CAP_SCALE;
            end
         end
         CAP_SCALE: begin
            next_cur.coilVoltageCode = scaledCode;
            next_cur.pointer = `PTR_ZERO_DEG;
            next_cur.capState = CAP_IDLE;
         end
         default: begin
            next_cur.capState = CAP_IDLE;
         end
      endcase

      // ----------------------------------------
      // Amplitude select
      // ----------------------------------------
      next_cur.fullScaleSel = amplitude_in_use(holdMode, next_cur.holdAmplitude,
         next_cur.runAmplitude);
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         cur <= RESET_STATE;
      end else begin
         cur <= next_cur;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign regRsp = cur.rsp;
   assign fullScaleSel = cur.fullScaleSel;
   assign latestCapturePointer = cur.pointer;
endmodule

//--- stepper_scale_chk.sv
// Port assertions for the stepper scale registers
`timescale 1ns/1ns
module stepper_scale_chk (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire stepper_scale_pkg::reg_req_t regReq,
   input wire stepper_scale_pkg::reg_rsp_t regRsp,
   input wire logic holdMode,
   input wire stepper_scale_pkg::coil_sample_t coilSample,
   input wire logic [3:0] fullScaleSel,
   input wire logic [1:0] latestCapturePointer
);
   import stepper_scale_pkg::*;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   sequence capStep;
      coilSample.sampleValid && {coilSample.phase[6], coilSample.phase[3:0]} == 5'h00;
   endsequence
   sequence scaleWrite;
      regReq.wrStrobe && regReq.addr == 7'h08;
   endsequence
   a_rd_answer: assert property (regReq.rdStrobe |=> regRsp.rdValid)
      else $error("no answer");
   a_rd_quiet: assert property (!regReq.rdStrobe |=> !regRsp.rdValid)
      else $error("stray answer");
   a_known_map: assert property (regReq.rdStrobe
      |=> regRsp.known == $past(regReq.addr[6:1] == 6'h04)) else $error("known flag");
   a_unmap_zero: assert property (regReq.rdStrobe && regReq.addr[6:1] != 6'h04
      |=> regRsp.rdData == 16'h0000) else $error("unmapped data");
   a_parity_zero: assert property (regRsp.rdValid |-> regRsp.rdData[0] == 1'b0)
      else $error("parity bit");
   a_rd_stands: assert property (!regReq.rdStrobe |=> $stable(regRsp.rdData))
      else $error("data moved");
   a_sel_steady: assert property ($stable(holdMode) &&
      !(regReq.wrStrobe && regReq.addr == 7'h08)
      |=> $stable(fullScaleSel)) else $error("select moved");
   a_sel_write: assert property (scaleWrite |=> fullScaleSel ==
      $past(holdMode ? regReq.wrData[15:12] : regReq.wrData[4:1])) else $error("select value");
   a_cap_ptr: assert property (capStep |-> ##2
      latestCapturePointer == $past(coilSample.phase[5:4], 2)) else $error("pointer");
endmodule
bind stepper_scale_regs stepper_scale_chk stepper_scale_chk_i (
   .clk_sys(clk_sys),
   .nrst(nrst),
   .regReq(regReq),
   .regRsp(regRsp),
   .holdMode(holdMode),
   .coilSample(coilSample),
   .fullScaleSel(fullScaleSel),
   .latestCapturePointer(latestCapturePointer)
);

//--- stepper_current_scale_and_coil_voltage_bench.sv
// Bench for the stepper scale registers
`timescale 1ns/1ns
module stepper_current_scale_and_coil_voltage_bench;
   import stepper_scale_pkg::*;
   logic clk_sys = 0, nrst = 0, holdMode = 0;
   reg_req_t regReq = '0;
   reg_rsp_t regRsp;
   coil_sample_t coilSample = '0;
   logic [3:0] fullScaleSel;
   logic [1:0] latestCapturePointer;
   int num_errors = 0, tests_run = 0;
   stepper_scale_regs stepper_scale_regs_i (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .regReq(regReq),
      .regRsp(regRsp),
      .holdMode(holdMode),
      .coilSample(coilSample),
      .fullScaleSel(fullScaleSel),
      .latestCapturePointer(latestCapturePointer)
   );
   always #25 clk_sys = ~clk_sys;
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %0t got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic acc(input logic w, input logic [6:0] a, input logic [15:0] d);
      regReq <= '{w, !w, a, d};
      @(posedge clk_sys) #5 regReq <= '0;
      if (!w) begin
         chk(regRsp.rdValid, 1'b1);
         chk(regRsp.rdData, d);
      end
      @(posedge clk_sys) #5;
   endtask
   task automatic t_regs;
      acc(0, 7'h08, 16'h0000);
      acc(0, 7'h09, 16'h0000);
      acc(1, 7'h08, 16'hAFEB);
      acc(0, 7'h08, 16'hA00A);
      chk(fullScaleSel, 4'h5);
      holdMode <= 1;
      @(posedge clk_sys) #5 chk(fullScaleSel, 4'hA);
      acc(1, 7'h09, 16'hFFFF);
      acc(0, 7'h09, 16'h0000);
      acc(0, 7'h0A, 16'h0000);
      chk(regRsp.known, 1'b0);
      $display("register test done");
   endtask
   task automatic samp(input logic [6:0] p, input logic [11:0] c, input logic [15:0] e);
      coilSample <= '{1'b1, p, c};
      @(posedge clk_sys) #5 coilSample <= '0;
      repeat (2) @(posedge clk_sys);
      #5 chk(latestCapturePointer, p[5:4]);
      acc(0, 7'h09, e);
   endtask
   task automatic t_cap;
      samp(7'h00, 12'hFFF, 16'h03FE);
      samp(7'h10, 12'h800, 16'h03FE);
      samp(7'h20, 12'h800, 16'h03FE);
      samp(7'h30, 12'h800, 16'h03FE);
      samp(7'h00, 12'h800, 16'h0200);
      $display("capture test done");
   endtask
   task automatic t_rst;
      nrst <= 0;
      @(posedge clk_sys) #5 chk(fullScaleSel, 4'h0);
      chk(regRsp.rdData, 16'h0000);
      nrst <= 1;
      acc(0, 7'h08, 16'h0000);
      acc(0, 7'h09, 16'h0000);
      $display("reset test done");
   endtask
   task summarize;
      $display("errors %0d checks %0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge clk_sys);
      #5 nrst <= 1;
      t_regs;
      t_cap;
      t_rst;
      summarize;
   end
   initial begin
      #20000;
      num_errors++;
      summarize;
   end
endmodule
